// >>> core/febo_error_break_out.sv
`timescale 1ns/1ps

// What this block does
// (R1) One shared pin: errors when stop request inactive, break events when active.
// (R2) Stop request deasserted: assert pin on detected unmasked floating-point error.
// (R3) Stop request asserted: assert pin while a break event is pending.
// (R4) Outside logic withdraws the stop request after seeing a break event.
// (R5) Break indication stays asserted until the stop request is deasserted.
// (R6) Probe request asserted during stop request counts as a break event; the code counts it only while break_report_enable_i is on.
// (R7) Shared pin, stop request and probe request are all active low.
module febo_error_break_out
#(
	parameter int NUM_BREAK_SRC = febo_pkg::FEBO_BREAK_SRC_DEF
)
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// system side
	input wire logic clock_stop_request_n_i,
	input wire logic probe_request_n_i,
	// processor core side
	input wire logic fp_error_event_i,
	input wire logic fp_error_clear_i,
	input wire logic [NUM_BREAK_SRC-1:0] break_event_i,
	input wire logic break_report_enable_i,
	// pin and status
	output logic fp_error_break_event_n_o,
	output febo_pkg::febo_status_s status_o
);
	import febo_pkg::*;

	// elaboration check
	if (NUM_BREAK_SRC < 1)
	begin : g_bad_param
		$error("NUM_BREAK_SRC must be at least 1");
	end

	// decoded requests
	logic stop_active;
	logic probe_active;
	logic probe_hit;
	logic [NUM_BREAK_SRC-1:0] src_hit;
	logic any_src_hit;
	// flag controls and flags
	logic break_set;
	logic break_clear;
	logic fp_set;
	logic fp_clear;
	logic fp_flag;
	logic next_fp_flag;
	logic brk_flag;
	logic next_brk_flag;
	// pin and meaning
	logic next_pin_n;
	febo_mode_e mode;
	febo_mode_e next_mode;

	// stop request decoded once, so no other logic compares the raw pin level
	always_comb
	begin
		stop_active = 1'h0;
		if (clock_stop_request_n_i == FEBO_ASSERTED_N)
		begin
			stop_active = 1'h1; // R7
		end
	end

	// probe request decoded the same way, as a level and not an edge
	always_comb
	begin
		probe_active = 1'h0;
		if (probe_request_n_i == FEBO_ASSERTED_N)
		begin
			probe_active = 1'h1; // R7
		end
	end

	// probe request only counts while the stop request is held and reporting is on
	always_comb
	begin
		probe_hit = 1'h0;
		if (stop_active && break_report_enable_i && probe_active)
		begin
			probe_hit = 1'h1; // R6
		end
	end

	// each further break source is qualified on its own in the same way
	for (genvar i = 0; i < NUM_BREAK_SRC; i++)
	begin : g_src
		assign src_hit[i] = stop_active && break_report_enable_i && break_event_i[i]; // R6
	end

	// qualified sources folded into one request
	assign any_src_hit = |src_hit;

	// probe or any source starts a pending break
	always_comb
	begin
		break_set = 1'h0;
		if (probe_hit || any_src_hit)
		begin
			break_set = 1'h1; // R6
		end
	end

	// a pending break only ends once the stop request is withdrawn
	always_comb
	begin
		break_clear = 1'h0;
		if (!stop_active)
		begin
			break_clear = 1'h1; // R5
		end
	end

	// error capture runs in both modes, so an error in a stop request is hidden, not lost
	always_comb
	begin
		fp_set = 1'h0;
		fp_clear = 1'h0;
		if (fp_error_event_i)
		begin
			fp_set = 1'h1; // R2
		end
		if (fp_error_clear_i)
		begin
			fp_clear = 1'h1;
		end
	end

	// unmasked floating-point error, held until the core clears it
	febo_sticky_flag u_fp_flag
	(
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.set_i(fp_set),
		.clear_i(fp_clear),
		.flag_o(fp_flag),
		.next_flag_o(next_fp_flag)
	);

	// pending break event
	febo_sticky_flag u_brk_flag
	(
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.set_i(break_set),
		.clear_i(break_clear),
		.flag_o(brk_flag),
		.next_flag_o(next_brk_flag)
	);

	// pin meaning follows the stop request, sampled like every other input
	always_comb
	begin
		next_mode = FEBO_MODE_ERROR;
		if (stop_active)
		begin
			next_mode = FEBO_MODE_BREAK; // R1
		end
	end

	// pin level for the coming cycle, picked by the coming meaning
	always_comb
	begin
		case (next_mode)
			FEBO_MODE_BREAK:
			begin
				next_pin_n = FEBO_PIN_IDLE_N;
				if (next_brk_flag)
				begin
					next_pin_n = FEBO_ASSERTED_N; // R3
				end
			end
			FEBO_MODE_ERROR:
			begin
				next_pin_n = FEBO_PIN_IDLE_N;
				if (next_fp_flag)
				begin
					next_pin_n = FEBO_ASSERTED_N; // R2
				end
			end
			default:
			begin
				next_pin_n = FEBO_PIN_IDLE_N;
			end
		endcase
	end

	// registered pin, aligned with the flag registers
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			fp_error_break_event_n_o <= FEBO_PIN_IDLE_N;
		end
		else
		begin
			fp_error_break_event_n_o <= next_pin_n; // R7
		end
	end

	// meaning register, aligned with the pin and the flag registers
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			mode <= FEBO_MODE_RST;
		end
		else
		begin
			mode <= next_mode; // R1
		end
	end

	// status read straight from the meaning and flag flip-flops
	always_comb
	begin
		status_o.mode = mode;
		status_o.fp_error_pending = fp_flag;
		status_o.break_pending = brk_flag;
	end

endmodule

// >>> core/febo_pkg.sv
package febo_pkg;

	// meaning currently carried by the shared pin
	typedef enum logic [0:0]
	{
		FEBO_MODE_ERROR = 1'h0,
		FEBO_MODE_BREAK = 1'h1
	} febo_mode_e;

	// observable state of the block
	typedef struct packed
	{
		febo_mode_e mode;
		logic fp_error_pending;
		logic break_pending;
	} febo_status_s;

	// reset values and the asserted pin level
	localparam logic FEBO_FLAG_RST = 1'h0;
	localparam logic FEBO_PIN_IDLE_N = 1'h1;
	localparam logic FEBO_ASSERTED_N = 1'h0;
	localparam febo_mode_e FEBO_MODE_RST = FEBO_MODE_ERROR;

	// default number of break event sources besides the probe request
	localparam int FEBO_BREAK_SRC_DEF = 1;

endpackage

// >>> core/febo_sticky_flag.sv
`timescale 1ns/1ps

// sticky flag: set wins over clear in the same cycle
module febo_sticky_flag
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic set_i,
	input wire logic clear_i,
	// state
	output logic flag_o,
	output logic next_flag_o
);
	import febo_pkg::*;

	// next value, set has priority so an event is never lost
	always_comb
	begin
		if (set_i)
		begin
			next_flag_o = 1'h1;
		end
		else if (clear_i)
		begin
			next_flag_o = 1'h0;
		end
		else
		begin
			next_flag_o = flag_o;
		end
	end

	// flag register
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			flag_o <= FEBO_FLAG_RST;
		end
		else
		begin
			flag_o <= next_flag_o;
		end
	end

endmodule

// >>> testbench/febo_asserts.sv
`timescale 1ns/1ps
module febo_asserts
#(
	parameter int NUM_BREAK_SRC = febo_pkg::FEBO_BREAK_SRC_DEF
)
(
	input wire logic sys_clk_i, rst_n_i, clock_stop_request_n_i, probe_request_n_i,
	input wire logic fp_error_event_i, fp_error_clear_i,
	input wire logic [NUM_BREAK_SRC-1:0] break_event_i,
	input wire logic break_report_enable_i, fp_error_break_event_n_o,
	input wire febo_pkg::febo_status_s status_o
);
	// short names for watched signals
	wire logic stp = clock_stop_request_n_i, pin = fp_error_break_event_n_o;
	wire logic mode = status_o.mode, brk = status_o.break_pending;
	wire logic fpe = status_o.fp_error_pending, src = |break_event_i;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// a break request during the stop request, then a break held under it
	sequence s_brk_req;
		!stp && break_report_enable_i && (!probe_request_n_i || src);
	endsequence
	sequence s_brk_held;
		!stp && brk;
	endsequence
	a_err_pin: assert property (!mode |-> pin == !fpe)
		else $error("error pin");
	a_brk_pin: assert property (##1 mode != $past(stp) && (!mode || pin == !brk))
		else $error("break pin");
	a_probe_brk: assert property (s_brk_req |=> brk && !pin)
		else $error("probe");
	a_brk_hold: assert property (s_brk_held |=> brk && !pin) else $error("hold");
	a_brk_end: assert property (stp |=> !brk && !mode) else $error("break end");
	a_fp_set: assert property (fp_error_event_i |=> fpe) else $error("error set");
	a_fp_clear: assert property (fp_error_clear_i && !fp_error_event_i |=> !fpe)
		else $error("error clear");
endmodule
bind febo_error_break_out febo_asserts #(.NUM_BREAK_SRC(NUM_BREAK_SRC)) u_chk(.sys_clk_i,
	.rst_n_i, .clock_stop_request_n_i, .probe_request_n_i, .fp_error_event_i,
	.fp_error_clear_i, .break_event_i, .break_report_enable_i, .fp_error_break_event_n_o,
	.status_o);

// >>> testbench/febo_error_break_out_bench.sv
`timescale 1ns/1ps
module febo_error_break_out_bench;
	logic sys_clk_i = 1'h0, rst_n_i = 1'h0, go = 1'h0, hold = 1'h1, probe_n = 1'h1;
	logic ev = 1'h0, en = 1'h0, clr = 1'h0, src = 1'h0, stop_n, pin_n;
	febo_pkg::febo_status_s st;
	int n_errors = 0, checks_done = 0;
	initial forever #5 sys_clk_i = ~sys_clk_i;
	febo_sys_model SYS(.sys_clk_i, .rst_n_i, .go_i(go), .hold_i(hold), .pin_n_i(pin_n),
		.stop_n_o(stop_n));
	febo_error_break_out DUT(.sys_clk_i, .rst_n_i, .clock_stop_request_n_i(stop_n),
		.probe_request_n_i(probe_n), .fp_error_event_i(ev), .fp_error_clear_i(clr),
		.break_event_i(src), .break_report_enable_i(en), .fp_error_break_event_n_o(pin_n),
		.status_o(st));
	task step(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task chk(input logic e);
		checks_done++;
		n_errors += (pin_n !== e);
		if (pin_n !== e)
			$display("wrong value %0t %h %h", $time, pin_n, e);
	endtask
	task chk_st(input logic [2:0] e);
		checks_done++;
		n_errors += (st !== e);
		if (st !== e)
			$display("wrong value %0t %h %h", $time, st, e);
	endtask
	task conclude;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// bounded wait for the system side to withdraw the stop request
	task wait_stop;
		repeat (9)
			if (stop_n !== 1'h1)
				step(1);
		n_errors += (stop_n !== 1'h1);
		if (stop_n !== 1'h1)
			conclude();
	endtask
	// error, then hidden in stop; probe break held; error back once stop drops
	task t_stop;
		{ev, go} = 2'h3;
		step(1);
		{ev, go, probe_n} = 3'h0;
		chk(1'h0);
		chk_st(3'h2);
		step(2);
		chk(1'h1);
		chk_st(3'h6);
		en = 1'h1;
		step(1);
		probe_n = 1'h1;
		step(3);
		chk(1'h0);
		chk_st(3'h7);
		hold = 1'h0;
		wait_stop();
		step(1);
		chk(1'h0);
		chk_st(3'h2);
	endtask
	// error cleared, set wins over clear; a break source ends in a withdrawn stop
	task t_src;
		clr = 1'h1;
		step(1);
		clr = 1'h0;
		chk(1'h1);
		{ev, clr} = 2'h3;
		step(1);
		{ev, clr} = 2'h0;
		chk(1'h0);
		{clr, hold, go} = 3'h7;
		step(1);
		{clr, go} = 2'h0;
		step(1);
		chk(1'h1);
		chk_st(3'h4);
		src = 1'h1;
		step(1);
		src = 1'h0;
		chk(1'h0);
		chk_st(3'h5);
		hold = 1'h0;
		wait_stop();
		step(1);
		chk(1'h1);
		chk_st(3'h0);
	endtask
	initial
	begin
		step(12);
		rst_n_i = 1'h1;
		step(1);
		t_stop();
		t_src();
		conclude();
	end
endmodule

// >>> testbench/febo_sys_model.sv
`timescale 1ns/1ps
// stop request on go, withdrawn on a break unless held
module febo_sys_model
(
	input wire logic sys_clk_i, rst_n_i, go_i, hold_i, pin_n_i,
	output logic stop_n_o
);
	logic held_n;
	// the pin means a break only once the stop request has stood a full cycle
	always_ff @(posedge sys_clk_i)
		held_n <= !rst_n_i || stop_n_o;
	always_ff @(posedge sys_clk_i)
		if (!rst_n_i || (!stop_n_o && !held_n && !pin_n_i && !hold_i))
			stop_n_o <= 1'h1;
		else if (go_i)
			stop_n_o <= 1'h0;
endmodule
